// ==== hdl/saa_pkg.sv ====
// Constants shared by the signal alarm annunciator.
// Assumes one system clock at 50 MHz and a synchronous active-high reset.
package saa_pkg;
  localparam int SAA_CLK_HZ = 50000000;
  localparam int SAA_TICK_MS = 100;
  localparam int SAA_TICK_CYCLES = SAA_CLK_HZ / 1000 * SAA_TICK_MS;
  localparam int SAA_NUM_ALARMS = 100;
  localparam int SAA_NUM_TIMERS = 210;
  localparam int SAA_IDX_W = 7;
  localparam int SAA_TMR_SEL_W = 8;
  localparam int SAA_TIME_W = 16;
  localparam logic [SAA_IDX_W-1:0] SAA_IDX_RESET = 7'h00;
  localparam logic [SAA_TIME_W-1:0] SAA_TIME_RESET = 16'h0000;
  localparam logic [SAA_TIME_W-1:0] SAA_TIME_MAX = 16'h7FFF;
endpackage : saa_pkg

// ==== hdl/saa_tick_div.sv ====
// Divider that makes the 100 ms tick enable for the hold timers.
// Assumes clk_sys at the package rate and synchronous reset.
`timescale 1ns/1ps
module saa_tick_div
  import saa_pkg::*;
#(
  parameter int TICK_CYCLES = SAA_TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  output logic tick
);
  logic [31:0] cnt_reg;

  // Counts cycles and pulses tick for one cycle each period.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_reg <= 32'h00000000;
      tick <= 1'b0;
    end else if (cnt_reg >= 32'(TICK_CYCLES - 1)) begin
      cnt_reg <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule : saa_tick_div

// ==== hdl/saa_annunciator.sv ====
// Signal alarm annunciator: hold-timed alarm set, latched bank, lowest-first reset.
// Assumes operations arrive as levels sampled once per scan strobe.
`timescale 1ns/1ps
module saa_annunciator
  import saa_pkg::*;
#(
  parameter int TICK_CYCLES = SAA_TICK_CYCLES,
  parameter int NUM_ALARMS = SAA_NUM_ALARMS,
  parameter int NUM_TIMERS = SAA_NUM_TIMERS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scan_strobe,
  input wire logic alarm_set_op,
  input wire logic [SAA_TMR_SEL_W-1:0] hold_timer_select,
  input wire logic [SAA_TIME_W-1:0] hold_time_threshold,
  input wire logic [SAA_IDX_W-1:0] alarm_target_index,
  input wire logic alarm_reset_op,
  input wire logic alarm_unit_enable,
  output logic any_alarm_active,
  output logic [SAA_IDX_W-1:0] lowest_active_alarm_index,
  output logic [NUM_ALARMS-1:0] alarm_flags,
  output logic [SAA_TIME_W-1:0] hold_timer_value
);
  logic tick;
  logic tick_pend_reg;
  logic [SAA_TIME_W-1:0] timer_reg [NUM_TIMERS];
  logic [NUM_ALARMS-1:0] flag_reg;
  logic reset_prev_reg;
  logic any_next;
  logic [SAA_IDX_W-1:0] low_next;
  logic sel_ok;
  logic tgt_ok;
  logic [SAA_TIME_W-1:0] cur_time;
  logic fire;
  logic clr_fire;

  saa_tick_div #(.TICK_CYCLES(TICK_CYCLES)) u_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(tick)
  );

  // A tick is remembered until the next scan so a scan consumes it.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_pend_reg <= 1'b0;
    end else if (tick) begin
      tick_pend_reg <= 1'b1;
    end else if (scan_strobe) begin
      tick_pend_reg <= 1'b0;
    end
  end

  // Operand range checks; out-of-range operands block the alarm set, but an out-of-range target still lets the selected timer count.
  assign sel_ok = 32'(hold_timer_select) < NUM_TIMERS;
  assign tgt_ok = 32'(alarm_target_index) < NUM_ALARMS;
  assign cur_time = sel_ok ? timer_reg[hold_timer_select] : SAA_TIME_RESET;
  assign fire = scan_strobe && alarm_set_op && sel_ok && tgt_ok
                && (hold_time_threshold != SAA_TIME_RESET)
                && (cur_time > hold_time_threshold);
  assign clr_fire = scan_strobe && alarm_reset_op && !reset_prev_reg;

  // Hold timers, one per index; only the selected one moves on a scan.
  generate
    for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_tmr
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          timer_reg[t] <= SAA_TIME_RESET;
        end else if (scan_strobe && sel_ok && 32'(hold_timer_select) == t) begin
          if (!alarm_set_op) begin
            timer_reg[t] <= SAA_TIME_RESET;
          end else if (timer_reg[t] > hold_time_threshold) begin
            timer_reg[t] <= timer_reg[t];
          end else if (timer_reg[t] < hold_time_threshold && !tick_pend_reg) begin
            timer_reg[t] <= timer_reg[t];
          end else if (tick_pend_reg && timer_reg[t] != SAA_TIME_MAX) begin
            timer_reg[t] <= timer_reg[t] + 16'h0001;
          end
        end
      end
    end
  endgenerate

  // Lowest active alarm search over the bank.
  always_comb begin
    any_next = 1'b0;
    low_next = SAA_IDX_RESET;
    for (int i = NUM_ALARMS - 1; i >= 0; i--) begin
      if (flag_reg[i]) begin
        any_next = 1'b1;
        low_next = SAA_IDX_W'(i);
      end
    end
  end

  // Alarm bank: set by a timed-out set operation, cleared lowest first.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_ALARMS; i++) begin
        if (fire && 32'(alarm_target_index) == i) begin
          flag_reg[i] <= 1'b1;
        end else if (clr_fire && any_next && 32'(low_next) == i) begin
          flag_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Edge memory for the reset operation, kept per scan.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reset_prev_reg <= 1'b0;
    end else if (scan_strobe) begin
      reset_prev_reg <= alarm_reset_op;
    end
  end

  // Summary outputs follow the bank only while the unit is enabled.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      any_alarm_active <= 1'b0;
      lowest_active_alarm_index <= SAA_IDX_RESET;
    end else if (alarm_unit_enable) begin
      any_alarm_active <= any_next;
      lowest_active_alarm_index <= low_next;
    end
  end

  // Registered copies of the bank and selected timer.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alarm_flags <= '0;
      hold_timer_value <= SAA_TIME_RESET;
    end else begin
      alarm_flags <= flag_reg;
      hold_timer_value <= cur_time;
    end
  end

  // A timed-out set operation latches its flag at the same edge.
  property set_latch_p;
    @(posedge clk_sys) disable iff (rst)
    fire |=> flag_reg[$past(alarm_target_index)];
  endproperty
  alarm_set_a: assert property (set_latch_p) else $error("Alarm not set after hold.");

  // A set operation still below its threshold never raises the flag.
  no_early_a: assert property (@(posedge clk_sys) disable iff (rst)
    (scan_strobe && alarm_set_op && cur_time < hold_time_threshold && tgt_ok
     && !flag_reg[alarm_target_index] && !clr_fire)
    |=> !flag_reg[$past(alarm_target_index)])
    else $error("Alarm set below threshold.");

  // Dropping the set condition clears the selected hold timer.
  timer_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    (scan_strobe && !alarm_set_op && sel_ok)
    |=> timer_reg[$past(hold_timer_select)] == SAA_TIME_RESET)
    else $error("Timer not cleared.");

  // Summary outputs hold still while the unit is disabled.
  enable_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !alarm_unit_enable |=> $stable(any_alarm_active) && $stable(lowest_active_alarm_index))
    else $error("Summary moved while disabled.");

  // The any-alarm output follows the bank one cycle later.
  any_alarm_a: assert property (@(posedge clk_sys) disable iff (rst)
    alarm_unit_enable |=> any_alarm_active == ($past(flag_reg) != 0))
    else $error("Any-alarm wrong.");

  // The reported lowest index points at an active flag unless the reset operation in that cycle has just cleared it.
  lowest_idx_a: assert property (@(posedge clk_sys) disable iff (rst)
    (alarm_unit_enable && any_next) |=> flag_reg[lowest_active_alarm_index] || $past(clr_fire))
    else $error("Lowest index not active.");

  // No active flag lies below the reported lowest index.
  lowest_min_a: assert property (@(posedge clk_sys) disable iff (rst)
    (alarm_unit_enable && any_next) |=> alarm_flags[lowest_active_alarm_index]
    && ((alarm_flags & ~({NUM_ALARMS{1'b1}} << lowest_active_alarm_index)) == '0))
    else $error("Lowest index not the smallest.");

  // A fresh reset operation removes exactly one active flag.
  sequence clr_seq;
    clr_fire && any_next && !fire;
  endsequence
  one_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    clr_seq |=> $countones($past(flag_reg)) - $countones(flag_reg) == 1)
    else $error("Not exactly one alarm cleared.");

  // A reset condition held from the last scan clears nothing more.
  sequence held_reset_seq;
    scan_strobe && reset_prev_reg && alarm_reset_op && !fire;
  endsequence
  fresh_edge_a: assert property (@(posedge clk_sys) disable iff (rst)
    held_reset_seq |=> flag_reg == $past(flag_reg))
    else $error("Held reset cleared again.");

  // Without a reset operation no flag ever drops.
  latch_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !clr_fire |=> (flag_reg & $past(flag_reg)) == $past(flag_reg))
    else $error("Alarm dropped without reset.");

  // Outside a scan the selected hold timer keeps its count.
  tick_step_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!scan_strobe && sel_ok)
    |=> timer_reg[$past(hold_timer_select)] == $past(cur_time))
    else $error("Timer moved outside a scan.");

  // A scan with a pending tick advances a timer that has not passed its threshold.
  sequence count_seq;
    scan_strobe && alarm_set_op && sel_ok && tick_pend_reg
    && cur_time <= hold_time_threshold && cur_time != SAA_TIME_MAX;
  endsequence
  timer_step_a: assert property (@(posedge clk_sys) disable iff (rst)
    count_seq |=> timer_reg[$past(hold_timer_select)] == $past(cur_time) + 16'h0001)
    else $error("Timer did not advance on a tick.");

  // A timer already past its threshold stops counting.
  timer_stop_a: assert property (@(posedge clk_sys) disable iff (rst)
    (scan_strobe && alarm_set_op && sel_ok && cur_time > hold_time_threshold)
    |=> timer_reg[$past(hold_timer_select)] == $past(cur_time))
    else $error("Timer counted past its threshold.");

  // A divider tick is always remembered for the next scan.
  tick_pend_a: assert property (@(posedge clk_sys) disable iff (rst)
    tick |=> tick_pend_reg)
    else $error("Tick not held for the scan.");
endmodule : saa_annunciator

// ==== tb/saa_annunciator_tb.sv ====
// Self-checking bench for the signal alarm annunciator.
// Assumes saa_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module saa_annunciator_tb;
  import saa_pkg::*;
  typedef struct {int kind; logic [99:0] val;} saa_note_s;
  logic clk_sys, rst, scan_strobe, alarm_set_op, alarm_reset_op, alarm_unit_enable;
  logic [SAA_TMR_SEL_W-1:0] hold_timer_select;
  logic [SAA_TIME_W-1:0] hold_time_threshold, hold_timer_value;
  logic [SAA_IDX_W-1:0] alarm_target_index, lowest_active_alarm_index;
  logic any_alarm_active;
  logic [99:0] alarm_flags, exp_flags, low_hold;
  saa_note_s note_q[$];
  saa_note_s cur;
  int bad_count, compares, cyc, idx;
  saa_annunciator #(.TICK_CYCLES(4)) dut_u (.clk_sys(clk_sys), .rst(rst),
    .scan_strobe(scan_strobe), .alarm_set_op(alarm_set_op),
    .hold_timer_select(hold_timer_select), .hold_time_threshold(hold_time_threshold),
    .alarm_target_index(alarm_target_index), .alarm_reset_op(alarm_reset_op),
    .alarm_unit_enable(alarm_unit_enable), .any_alarm_active(any_alarm_active),
    .lowest_active_alarm_index(lowest_active_alarm_index), .alarm_flags(alarm_flags),
    .hold_timer_value(hold_timer_value));
  // Free-running 20 ns clock.
  always #10 clk_sys = ~clk_sys;
  task automatic give_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // A cycle ceiling cuts a hang short.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic cmp_vec(input logic [99:0] g, input logic [99:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t vector %h expected %h", $time, g, e);
    end
  endtask : cmp_vec
  task automatic cmp_bit(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t any-alarm %b expected %b", $time, g, e);
    end
  endtask : cmp_bit
  task automatic cmp_idx(input logic [6:0] g, input logic [6:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t lowest index %0d expected %0d", $time, g, e);
    end
  endtask : cmp_idx
  // Takes each noted expectation once outputs settle and compares it.
  always @(negedge clk_sys) begin
    #1;
    while (note_q.size() > 0) begin
      cur = note_q.pop_front();
      case (cur.kind)
        0: cmp_vec(alarm_flags, cur.val);
        1: cmp_bit(any_alarm_active, cur.val[0]);
        2: cmp_idx(lowest_active_alarm_index, cur.val[6:0]);
        default: cmp_vec({84'h0, hold_timer_value}, cur.val);
      endcase
    end
  end
  function automatic logic [99:0] low_of(input logic [99:0] f);
    for (int i = 0; i < 100; i++) if (f[i]) return 100'(i);
    return 100'h0;
  endfunction : low_of
  task automatic note(input int k, input logic [99:0] v);
    note_q.push_back('{k, v});
  endtask : note
  task automatic note_all();
    note(0, exp_flags);
    note(1, {99'h0, |exp_flags});
    note(2, low_of(exp_flags));
  endtask : note_all
  // Scans spaced wider than the tick, then room for the summary latency.
  task automatic scan(input int n);
    repeat (n) begin
      repeat (8) @(negedge clk_sys);
      scan_strobe = 1'b1;
      @(negedge clk_sys);
      scan_strobe = 1'b0;
    end
    repeat (3) @(negedge clk_sys);
  endtask : scan
  task automatic hold_set(input logic [6:0] t, input int n);
    alarm_target_index = t;
    alarm_set_op = 1'b1;
    scan(n);
    alarm_set_op = 1'b0;
    scan(1);
    if (t < 100) exp_flags[t] = 1'b1;
  endtask : hold_set
  // Main sequence: timed set, latched bank, disabled summaries, lowest-first clear.
  initial begin
    {clk_sys, scan_strobe, alarm_set_op, alarm_reset_op} = 4'h0;
    rst = 1'b1;
    alarm_unit_enable = 1'b1;
    hold_timer_select = 8'h05;
    hold_time_threshold = 16'h0003;
    alarm_target_index = 7'h00;
    exp_flags = '0;
    void'($urandom(32'hB0E62096));
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    note_all();
    idx = $urandom % 100;
    alarm_target_index = idx[6:0];
    alarm_set_op = 1'b1;
    scan(3);
    note(3, 100'h3);
    note_all();
    scan(3);
    exp_flags[idx] = 1'b1;
    note_all();
    alarm_set_op = 1'b0;
    scan(1);
    note(3, 100'h0);
    note_all();
    hold_time_threshold = 16'h0001;
    hold_set(7'h63, 3);
    hold_set(7'h64, 3);
    // A zero threshold and an out-of-range timer must both leave the bank alone.
    alarm_target_index = 7'h62;
    alarm_set_op = 1'b1;
    hold_time_threshold = 16'h0000;
    scan(3);
    hold_time_threshold = 16'h0001;
    hold_timer_select = 8'hD2;
    scan(3);
    note(3, 100'h0);
    hold_timer_select = 8'h05;
    alarm_set_op = 1'b0;
    scan(1);
    note(0, exp_flags);
    for (int i = 0; i < 3; i++) hold_set(7'($urandom % 100), 3);
    note_all();
    alarm_unit_enable = 1'b0;
    low_hold = low_of(exp_flags);
    note(1, 100'h1);
    note(2, low_hold);
    alarm_reset_op = 1'b1;
    scan(1);
    exp_flags[low_of(exp_flags)] = 1'b0;
    note(0, exp_flags);
    note(1, 100'h1);
    note(2, low_hold);
    scan(2);
    note(0, exp_flags);
    alarm_reset_op = 1'b0;
    alarm_unit_enable = 1'b1;
    scan(1);
    while (exp_flags != '0) begin
      alarm_reset_op = 1'b1;
      scan(1);
      alarm_reset_op = 1'b0;
      scan(1);
      exp_flags[low_of(exp_flags)] = 1'b0;
      note_all();
    end
    repeat (3) @(negedge clk_sys);
    give_verdict();
  end
endmodule : saa_annunciator_tb
